// ===== src/cmec_pkg.sv
// Constants shared by the compare match event counter.
package cmec_pkg;
    // Register byte offsets.
    localparam logic [7:0] CMEC_CMD_OFS = 8'h00;
    localparam logic [7:0] CMEC_CFG_OFS = 8'h04;
    localparam logic [7:0] CMEC_STAT_OFS = 8'h08;
    localparam logic [7:0] CMEC_COUNT_OFS = 8'h0c;
    localparam logic [7:0] CMEC_CMP_OFS = 8'h10;
    localparam logic [7:0] CMEC_PRESET_OFS = 8'h14;
    localparam logic [7:0] CMEC_CMPTAB_OFS = 8'h40;
    localparam logic [7:0] CMEC_PRETAB_OFS = 8'h80;
    // Command register bits.
    localparam int CMEC_CMD_START = 0;
    localparam int CMEC_CMD_STOP = 1;
    localparam int CMEC_CMD_CRESET = 2;
    localparam int CMEC_CMD_SRESET = 3;
    // Configuration register fields.
    localparam int CMEC_CFG_SRC = 0;
    localparam int CMEC_CFG_FILT_LO = 1;
    localparam int CMEC_CFG_CMPEN = 3;
    localparam int CMEC_CFG_CMPWRAP = 4;
    localparam int CMEC_CFG_PREEN = 5;
    localparam int CMEC_CFG_PREWRAP = 6;
    localparam int CMEC_CFG_CMPLAST_LO = 8;
    localparam int CMEC_CFG_PRELAST_LO = 12;
    localparam logic [31:0] CMEC_CFG_MASK = 32'h0000_777f;
    localparam logic [31:0] CMEC_CFG_RESET = 32'h0000_0000;
    // Status register bits.
    localparam int CMEC_ST_RUN = 0;
    localparam int CMEC_ST_MATCH = 1;
    localparam int CMEC_ST_OVR = 2;
    localparam int CMEC_ST_ERR = 3;
    // Tables.
    localparam int CMEC_TAB_DEPTH = 8;
    localparam int CMEC_IDX_W = 3;
    localparam logic [31:0] CMEC_CMP_RESET = 32'hffff_ffff;
    // Filter times and their cycle counts at the 25 MHz clock.
    localparam int CMEC_CLK_HZ = 25_000_000;
    localparam int CMEC_FILT_1US_NS = 1_000;
    localparam int CMEC_FILT_128US_NS = 128_000;
    localparam int CMEC_FILT_16MS_NS = 16_000_000;
    localparam int CMEC_CLK_NS = 1_000_000_000 / CMEC_CLK_HZ;
    localparam int CMEC_FILT_1US_CYC = (CMEC_FILT_1US_NS + CMEC_CLK_NS - 1) / CMEC_CLK_NS;
    localparam int CMEC_FILT_128US_CYC = (CMEC_FILT_128US_NS + CMEC_CLK_NS - 1) / CMEC_CLK_NS;
    localparam int CMEC_FILT_16MS_CYC = (CMEC_FILT_16MS_NS + CMEC_CLK_NS - 1) / CMEC_CLK_NS;
    localparam int CMEC_FILT_W = 19;
    // Filter selections.
    typedef enum logic [1:0] {
        CMEC_FILT_OFF,
        CMEC_FILT_1US,
        CMEC_FILT_128US,
        CMEC_FILT_16MS
    } cmec_filt_type;
endpackage

// ===== src/cmec_counter.sv
// Compare match event counter with Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
module cmec_counter
    import cmec_pkg::*;
#(
    parameter int FILT_16MS_CYC = CMEC_FILT_16MS_CYC
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset,
    // Avalon-MM slave.
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Count inputs.
    input wire logic i_ext_clk,
    input wire logic i_event_in,
    // Event notifications and state.
    output logic o_match_event,
    output logic o_overrun_event,
    output logic o_error_event,
    output logic o_running
);

    // Next table index: wraps to zero, or holds at the last entry when wrap is off.
    function automatic logic [CMEC_IDX_W-1:0] next_idx(
        input logic [CMEC_IDX_W-1:0] idx,
        input logic [CMEC_IDX_W-1:0] last,
        input logic wrap
    );
        logic [CMEC_IDX_W-1:0] r;
        r = idx + 1'b1;
        if (idx >= last)
        begin
            r = wrap ? '0 : last;
        end
        return r;
    endfunction

    function automatic logic [CMEC_FILT_W-1:0] filt_len(input cmec_filt_type sel, input int l16);
        logic [CMEC_FILT_W-1:0] r;
        r = CMEC_FILT_W'(1);
        unique case (sel)
            CMEC_FILT_OFF: r = CMEC_FILT_W'(1);
            CMEC_FILT_1US: r = CMEC_FILT_W'(CMEC_FILT_1US_CYC);
            CMEC_FILT_128US: r = CMEC_FILT_W'(CMEC_FILT_128US_CYC);
            CMEC_FILT_16MS: r = CMEC_FILT_W'(l16);
        endcase
        return r;
    endfunction

    // Bus handshake: one wait cycle, data registered at the first edge.
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    wire bus_req = i_avs_read | i_avs_write;
    wire bus_first = bus_req & wait_q;
    wire wr_go = i_avs_write & ~wait_q;
    wire [7:0] addr = i_avs_address;
    wire tab_hit_c = (addr[7:5] == CMEC_CMPTAB_OFS[7:5]) && (addr[1:0] == 2'b00);
    wire tab_hit_p = (addr[7:5] == CMEC_PRETAB_OFS[7:5]) && (addr[1:0] == 2'b00);
    wire [CMEC_IDX_W-1:0] tab_sel = addr[CMEC_IDX_W+1:2];

    // Write decode.
    wire wr_cmd = wr_go && (addr == CMEC_CMD_OFS);
    wire wr_cfg = wr_go && (addr == CMEC_CFG_OFS);
    wire wr_cmp = wr_go && (addr == CMEC_CMP_OFS);
    wire wr_pre = wr_go && (addr == CMEC_PRESET_OFS);
    wire wr_ctab = wr_go && tab_hit_c;
    wire wr_ptab = wr_go && tab_hit_p;
    wire cmd_start = wr_cmd & i_avs_writedata[CMEC_CMD_START];
    wire cmd_stop = wr_cmd & i_avs_writedata[CMEC_CMD_STOP];
    wire cmd_creset = wr_cmd & i_avs_writedata[CMEC_CMD_CRESET];
    wire cmd_sreset = wr_cmd & i_avs_writedata[CMEC_CMD_SRESET];
    // A counter reset shares the power-on path so no counter state can be missed.
    wire rst_all = i_reset | cmd_creset;

    // Configuration.
    logic [31:0] cfg_q;
    wire cfg_src = cfg_q[CMEC_CFG_SRC];
    wire cmec_filt_type filt_sel = cmec_filt_type'(cfg_q[CMEC_CFG_FILT_LO +: 2]);
    wire cmp_en = cfg_q[CMEC_CFG_CMPEN];
    wire cmp_wrap = cfg_q[CMEC_CFG_CMPWRAP];
    wire pre_en = cfg_q[CMEC_CFG_PREEN];
    wire pre_wrap = cfg_q[CMEC_CFG_PREWRAP];
    wire [CMEC_IDX_W-1:0] cmp_last = cfg_q[CMEC_CFG_CMPLAST_LO +: CMEC_IDX_W];
    wire [CMEC_IDX_W-1:0] pre_last = cfg_q[CMEC_CFG_PRELAST_LO +: CMEC_IDX_W];

    // Tables.
    logic [31:0] cmp_tab_q [CMEC_TAB_DEPTH];
    logic [31:0] pre_tab_q [CMEC_TAB_DEPTH];

    // Input selection and filter.
    wire raw_in = cfg_src ? i_event_in : i_ext_clk;
    logic filt_q;
    logic filt_prev_q;
    logic [CMEC_FILT_W-1:0] stab_q;
    logic [CMEC_FILT_W-1:0] stab_d;
    logic filt_d;
    wire [CMEC_FILT_W-1:0] flen = filt_len(filt_sel, FILT_16MS_CYC);

    // Any bounce restarts the stability count, so a pulse shorter than the filter
    // time never reaches the counter; the price is a full filter time of delay.
    always_comb
    begin
        filt_d = filt_q;
        stab_d = '0;
        if (filt_sel == CMEC_FILT_OFF)
        begin
            filt_d = raw_in;
        end
        else if (raw_in != filt_q)
        begin
            stab_d = stab_q + 1'b1;
            if (stab_d >= flen)
            begin
                filt_d = raw_in;
                stab_d = '0;
            end
        end
    end

    // Counter core.
    logic running_q;
    logic match_q;
    logic ovr_q;
    logic err_q;
    logic [31:0] count_q;
    logic [31:0] cmp_q;
    logic [CMEC_IDX_W-1:0] cidx_q;
    logic [CMEC_IDX_W-1:0] pidx_q;
    logic ev_match_q;
    logic ev_ovr_q;
    logic ev_err_q;

    // The previous level resets low, the idle level of both count inputs, so
    // leaving reset never looks like a count edge.
    wire edge_in = filt_q & ~filt_prev_q;
    wire [31:0] count_inc = count_q + 32'h0000_0001;
    wire hit = running_q & edge_in & (count_inc == cmp_q);
    wire is_ovr = hit & match_q;
    // Software has not serviced the last overrun, so another match is lost.
    wire is_err = hit & ovr_q;
    wire [CMEC_IDX_W-1:0] cidx_n = next_idx(cidx_q, cmp_last, cmp_wrap);
    wire [CMEC_IDX_W-1:0] pidx_n = next_idx(pidx_q, pre_last, pre_wrap);
    wire cmp_stuck = ~cmp_wrap & (cidx_q >= cmp_last);

    always_ff @(posedge i_mclk)
    begin
        if (rst_all)
        begin
            cfg_q <= CMEC_CFG_RESET;
            filt_q <= 1'b0;
            filt_prev_q <= 1'b0;
            stab_q <= '0;
        end
        else
        begin
            if (wr_cfg)
            begin
                cfg_q <= i_avs_writedata & CMEC_CFG_MASK;
            end
            filt_q <= filt_d;
            filt_prev_q <= filt_q;
            stab_q <= stab_d;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (rst_all)
        begin
            for (int i = 0; i < CMEC_TAB_DEPTH; i++)
            begin
                cmp_tab_q[i] <= '0;
                pre_tab_q[i] <= '0;
            end
        end
        else
        begin
            if (wr_ctab)
            begin
                cmp_tab_q[tab_sel] <= i_avs_writedata;
            end
            if (wr_ptab)
            begin
                pre_tab_q[tab_sel] <= i_avs_writedata;
            end
        end
    end

    // Running state.
    always_ff @(posedge i_mclk)
    begin
        if (rst_all)
        begin
            running_q <= 1'b0;
            err_q <= 1'b0;
        end
        else if (cmd_stop | is_err)
        begin
            running_q <= 1'b0;
            err_q <= err_q | is_err;
        end
        else if (cmd_start)
        begin
            running_q <= 1'b1;
            err_q <= 1'b0;
        end
    end

    // Sticky match and overrun flags; a new match beats a status reset.
    always_ff @(posedge i_mclk)
    begin
        if (rst_all)
        begin
            match_q <= 1'b0;
            ovr_q <= 1'b0;
        end
        else
        begin
            match_q <= hit | (match_q & ~cmd_sreset & ~cmd_start);
            ovr_q <= is_ovr | (ovr_q & ~cmd_sreset);
        end
    end

    // Count, compare and table indices.
    always_ff @(posedge i_mclk)
    begin
        if (rst_all)
        begin
            count_q <= '0;
            cmp_q <= CMEC_CMP_RESET;
            cidx_q <= '0;
            pidx_q <= '0;
        end
        else if (cmd_start & ~cmd_stop)
        begin
            cidx_q <= '0;
            pidx_q <= '0;
            if (cmp_en)
            begin
                cmp_q <= cmp_tab_q[0];
            end
            if (pre_en)
            begin
                count_q <= '0;
            end
        end
        else
        begin
            if (wr_pre)
            begin
                count_q <= i_avs_writedata;
            end
            else if (hit & ~is_err & pre_en)
            begin
                count_q <= pre_tab_q[pidx_q];
                pidx_q <= pidx_n;
            end
            else if (running_q & edge_in & ~is_err)
            begin
                count_q <= count_inc;
            end
            if (wr_cmp)
            begin
                cmp_q <= i_avs_writedata;
            end
            else if (hit & ~is_err & cmp_en & ~cmp_stuck)
            begin
                cmp_q <= cmp_tab_q[cidx_n];
                cidx_q <= cidx_n;
            end
        end
    end

    // Event pulses.
    always_ff @(posedge i_mclk)
    begin
        if (rst_all)
        begin
            ev_match_q <= 1'b0;
            ev_ovr_q <= 1'b0;
            ev_err_q <= 1'b0;
        end
        else
        begin
            ev_match_q <= hit;
            ev_ovr_q <= is_ovr;
            ev_err_q <= is_err;
        end
    end

    // Read mux; reads have no side effects on counting.
    always_comb
    begin
        rdata_d = '0;
        if (tab_hit_c)
        begin
            rdata_d = cmp_tab_q[tab_sel];
        end
        else if (tab_hit_p)
        begin
            rdata_d = pre_tab_q[tab_sel];
        end
        else
        begin
            unique case (addr)
                CMEC_CFG_OFS: rdata_d = cfg_q;
                CMEC_STAT_OFS: rdata_d = {28'h0000000, err_q, ovr_q, match_q, running_q};
                CMEC_COUNT_OFS: rdata_d = count_q;
                CMEC_CMP_OFS: rdata_d = cmp_q;
                CMEC_PRESET_OFS: rdata_d = count_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // Bus handshake registers stay out of the counter reset so a
    // command write still completes its transfer cleanly.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end
        else
        begin
            wait_q <= ~bus_first;
            if (bus_first & i_avs_read)
            begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata = rdata_q;
    assign o_match_event = ev_match_q;
    assign o_overrun_event = ev_ovr_q;
    assign o_error_event = ev_err_q;
    assign o_running = running_q;

endmodule
`default_nettype wire

// ===== tb/cmec_counter_sva.sv
// Bus handshake and event checks for the compare match event counter.
`timescale 1ns/1ns
`default_nettype none
module cmec_counter_sva
    import cmec_pkg::*;
#(
    parameter int FILT_16MS_CYC = CMEC_FILT_16MS_CYC
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset,
    // Bus.
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Count inputs and events.
    input wire logic i_ext_clk,
    input wire logic i_event_in,
    input wire logic o_match_event,
    input wire logic o_overrun_event,
    input wire logic o_error_event,
    input wire logic o_running
);
    wire logic cmd_w;
    wire logic start_w;
    wire logic stop_w;
    assign cmd_w = i_avs_write && !o_avs_waitrequest && (i_avs_address == CMEC_CMD_OFS);
    assign start_w = cmd_w && i_avs_writedata[0] && !i_avs_writedata[1];
    assign stop_w = cmd_w && (i_avs_writedata[1] || i_avs_writedata[2]);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    bus_ack_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("answer late");
    ack_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer too long");
    start_run_a: assert property (start_w |-> ##[1:2] o_running)
        else $error("start ignored");
    stop_halt_a: assert property (stop_w |=> ##[0:1] !o_running)
        else $error("stop ignored");
    rise_cause_a: assert property ($rose(o_running) |-> $past(start_w) || $past(start_w, 2))
        else $error("run without start");
    err_halt_a: assert property (o_error_event |-> ##[0:2] !o_running)
        else $error("error did not halt");
    idle_quiet_a: assert property (!o_running [*3] |-> !o_match_event && !o_overrun_event)
        else $error("event while idle");
    ovr_runs_a: assert property (o_overrun_event && !o_error_event |-> o_running)
        else $error("overrun halted");
    cover property (o_match_event);
    cover property (o_overrun_event);
    cover property (o_error_event);
endmodule
bind cmec_counter cmec_counter_sva #(.FILT_16MS_CYC(FILT_16MS_CYC)) u_sva (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_ext_clk(i_ext_clk), .i_event_in(i_event_in), .o_match_event(o_match_event),
    .o_overrun_event(o_overrun_event), .o_error_event(o_error_event), .o_running(o_running));
`default_nettype wire

// ===== tb/cmec_pulse_src.sv
// Count source model: one pulse per request on the selected line.
`timescale 1ns/1ns
`default_nettype none
module cmec_pulse_src (
    input wire logic i_mclk,
    input wire logic i_src,
    input wire logic i_fire,
    input wire logic [12:0] i_width,
    output logic o_ext_clk,
    output logic o_event_in,
    output logic o_busy
);
    logic [13:0] cnt_q = '0;
    logic idle_q = 1'b0;
    wire logic lvl;
    // Low for width cycles, then high for width cycles: one rising edge.
    assign lvl = (cnt_q != '0) && (cnt_q <= {1'b0, i_width});
    assign o_busy = (cnt_q != '0);
    // The unselected line toggles every cycle so that it must be ignored.
    assign o_ext_clk = i_src ? idle_q : lvl;
    assign o_event_in = i_src ? lvl : idle_q;
    always_ff @(posedge i_mclk)
    begin
        idle_q <= ~idle_q;
        if (cnt_q != '0)
            cnt_q <= cnt_q - 14'h1;
        else if (i_fire)
            cnt_q <= {i_width, 1'b0};
    end
endmodule
`default_nettype wire

// ===== tb/test_cmec_counter.sv
// Self-checking bench for the compare match event counter.
`timescale 1ns/1ns
`default_nettype none
module test_cmec_counter;
    import cmec_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, v;
    logic wait_s, run_s, ext_s, evt_s, busy_s;
    logic m_ev, o_ev, e_ev;
    logic src_s = 1'b0;
    logic fire = 1'b0;
    logic [12:0] wid = 13'h0002;
    int err_total = 0;
    int total_checks = 0;
    int n_match = 0;
    int n_ovr = 0;
    int n_err = 0;
    initial
    begin
        forever #20 i_mclk = ~i_mclk;
    end
    cmec_counter #(.FILT_16MS_CYC(40)) dut (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_s), .i_ext_clk(ext_s),
        .i_event_in(evt_s), .o_match_event(m_ev), .o_overrun_event(o_ev), .o_error_event(e_ev),
        .o_running(run_s));
    cmec_pulse_src src (.i_mclk(i_mclk), .i_src(src_s), .i_fire(fire), .i_width(wid),
        .o_ext_clk(ext_s), .o_event_in(evt_s), .o_busy(busy_s));
    // Event pulses are counted so that the count and error scenarios can judge them later.
    always @(posedge i_mclk)
    begin
        if (m_ev === 1'b1)
            n_match <= n_match + 1;
        if (o_ev === 1'b1)
            n_ovr <= n_ovr + 1;
        if (e_ev === 1'b1)
            n_err <= n_err + 1;
    end
    task automatic results();
    begin
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
    begin
        n = 0;
        rd_s <= ~w;
        wr_s <= w;
        adr <= a;
        wd <= d;
        @(posedge i_mclk);
        while (wait_s !== 1'b0 && n < 50)
        begin
            @(posedge i_mclk);
            n++;
        end
        v = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge i_mclk);
        if (n == 50)
        begin
            err_total++;
            results();
        end
    end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    begin
        bus(1'b0, a, 32'h0);
        chk(nm, e, v);
    end
    endtask
    task automatic pulse(input int k, input logic [12:0] w);
        int n;
    begin
        wid <= w;
        repeat (k)
        begin
            fire <= 1'b1;
            @(posedge i_mclk);
            fire <= 1'b0;
            @(posedge i_mclk);
            n = 0;
            while (busy_s !== 1'b0 && n < 9000)
            begin
                @(posedge i_mclk);
                n++;
            end
            if (n == 9000)
            begin
                err_total++;
                results();
            end
            repeat (6) @(posedge i_mclk);
        end
    end
    endtask
    task automatic s_reset();
    begin
        bus(1'b1, 8'h20, 32'h5);
        rchk(8'h20, 32'h0, "unmapped");
        rchk(CMEC_CFG_OFS, CMEC_CFG_RESET, "cfg");
        rchk(CMEC_CMP_OFS, CMEC_CMP_RESET, "cmp");
        rchk(CMEC_STAT_OFS, 32'h0, "stat");
    end
    endtask
    task automatic s_count();
    begin
        bus(1'b1, CMEC_CMP_OFS, 32'h3);
        bus(1'b1, CMEC_CMD_OFS, 32'h1);
        rchk(CMEC_STAT_OFS, 32'h1, "run");
        chk("running", 32'h1, run_s);
        pulse(2, 13'h2);
        rchk(CMEC_COUNT_OFS, 32'h2, "count");
        pulse(1, 13'h2);
        rchk(CMEC_STAT_OFS, 32'h3, "match");
        bus(1'b1, CMEC_PRESET_OFS, 32'h2);
        rchk(CMEC_COUNT_OFS, 32'h2, "preset");
        pulse(1, 13'h2);
        rchk(CMEC_STAT_OFS, 32'h7, "ovr");
        bus(1'b1, CMEC_CMD_OFS, 32'h8);
        rchk(CMEC_STAT_OFS, 32'h1, "sreset");
        bus(1'b1, CMEC_CMD_OFS, 32'h2);
        pulse(1, 13'h2);
        rchk(CMEC_STAT_OFS, 32'h0, "stop");
        chk("stopped", 32'h0, run_s);
        rchk(CMEC_COUNT_OFS, 32'h3, "held");
        chk("match events", 32'h2, n_match);
        chk("overrun events", 32'h1, n_ovr);
    end
    endtask
    task automatic s_error();
    begin
        bus(1'b1, CMEC_PRETAB_OFS, 32'h0);
        bus(1'b1, CMEC_CMP_OFS, 32'h1);
        bus(1'b1, CMEC_CFG_OFS, 32'h20);
        bus(1'b1, CMEC_CMD_OFS, 32'h1);
        rchk(CMEC_COUNT_OFS, 32'h0, "zero");
        pulse(3, 13'h2);
        rchk(CMEC_STAT_OFS, 32'he, "err");
        chk("halted", 32'h0, run_s);
        chk("match events", 32'h5, n_match);
        chk("overrun events", 32'h3, n_ovr);
        chk("error events", 32'h1, n_err);
        rchk(CMEC_COUNT_OFS, 32'h0, "jump");
        bus(1'b1, CMEC_CMD_OFS, 32'h4);
        rchk(CMEC_CFG_OFS, 32'h0, "cfg");
        rchk(CMEC_STAT_OFS, 32'h0, "stat");
    end
    endtask
    task automatic s_table();
    begin
        bus(1'b1, CMEC_CMPTAB_OFS, 32'h2);
        bus(1'b1, CMEC_CMPTAB_OFS + 8'h04, 32'h4);
        bus(1'b1, CMEC_PRETAB_OFS + 8'h04, 32'h1);
        for (int w = 0; w < 2; w++)
        begin
            bus(1'b1, CMEC_CFG_OFS, {25'h0, w[0], 1'b0, w[0], 4'h0} | 32'h1128);
            bus(1'b1, CMEC_CMD_OFS, 32'h1);
            pulse(2, 13'h2);
            rchk(CMEC_CMP_OFS, 32'h4, "next");
            pulse(4, 13'h2);
            rchk(CMEC_CMP_OFS, w ? 32'h2 : 32'h4, "last");
            rchk(CMEC_STAT_OFS, 32'h7, "hits");
            rchk(CMEC_COUNT_OFS, 32'h1, "second preset");
            bus(1'b1, CMEC_CMD_OFS, 32'h8);
            pulse(1, 13'h2);
            rchk(CMEC_COUNT_OFS, w ? 32'h0 : 32'h2, "preset wrap");
            bus(1'b1, CMEC_CMD_OFS, 32'ha);
        end
    end
    endtask
    task automatic s_filter();
        int cy;
        logic [31:0] c0;
    begin
        src_s <= 1'b1;
        for (int f = 1; f < 4; f++)
        begin
            cy = (f == 1) ? 25 : (f == 2) ? 3200 : 40;
            bus(1'b1, CMEC_CFG_OFS, {29'h0, f[1:0], 1'b1});
            bus(1'b1, CMEC_CMD_OFS, 32'h1);
            bus(1'b0, CMEC_COUNT_OFS, 32'h0);
            c0 = v;
            pulse(1, 13'(cy / 2));
            rchk(CMEC_COUNT_OFS, c0, "short");
            pulse(1, 13'(cy + 8));
            rchk(CMEC_COUNT_OFS, c0 + 32'h1, "long");
            // Let the filtered level fall again so the next filter starts from low.
            repeat (cy + 8) @(posedge i_mclk);
            bus(1'b1, CMEC_CMD_OFS, 32'h2);
        end
    end
    endtask
    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        s_reset();
        s_count();
        s_error();
        s_table();
        s_filter();
        results();
    end
endmodule
`default_nettype wire
